//--- rtl/power_mode_and_clock_out_ctrl.sv
// power modes, pin wake-up, slow-down divider, baud timer and three toggle clock outputs
// assumes timers 0/1 deliver one-cycle overflow pulses and the interrupt block reports
// which sources are enabled; wake pins and the low-voltage detector are asynchronous
//
// Functional notes
// - capture pin edge wakes power-down when enabled
// - receive pin edge wakes power-down when enabled
// - timer-1 pin edge wakes power-down when enabled
// - timer-0 pin edge wakes power-down when enabled
// - comparator pin edge wakes power-down when enabled
// - timer-0 overflow toggles its clock-out latch
// - timer-1 overflow toggles its clock-out latch
// - baud timer overflow toggles its clock-out latch
// - timer-0 clock-out follows reload byte law
// - counter mode timer-0 clock-out follows pin rate
// - timer-1 clock-out follows same reload law
// - baud clock-out: clock, /12 option, reload, /2
// - baud reload register reloads timer on overflow
// - idle bit gates only the cpu clock
// - power-down bit stops oscillator, pins wake
// - low-voltage flag set by hardware, software clears
// - power-on flag set at power-up, software clears
// - baud-double bit doubles serial baud rate
// - frame-error select steers serial control top bit
// - bits 3 and 2 are plain flags
// - non-zero divider field slows internal clock
// - divider is two to the field value
// - enabled interrupt in idle clears idle bit
// - pin wake holds clock for 32768 cycles
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
`include "pwr_clk_cfg.svh"

module power_mode_and_clock_out_ctrl
	import pwr_clk_pkg::*;
#(
	parameter int unsigned SETTLE_CYCLES = `SETTLE_OSC_CYCLES
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// avalon-mm slave
	input  wire logic [9:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output var  logic [31:0] readdata,
	output logic             waitrequest,
	// wake pins and detector, asynchronous
	input  wire wake_pins_t  wake_pins,
	input  wire logic        low_voltage_detect,
	// interrupt enables per wake source, same clock
	input  wire wake_pins_t  wake_irq_enable,
	input  wire logic        irq_request,
	// timer overflow pulses and port latches, same clock
	input  wire logic        timer0_overflow,
	input  wire logic        timer1_overflow,
	input  wire logic        port_latch_timer0_pin,
	input  wire logic        port_latch_timer1_pin,
	input  wire logic        port_latch_baud_pin,
	// clock output pins
	output var  logic        clock_out0_pin,
	output var  logic        clock_out1_pin,
	output var  logic        clock_out2_pin,
	// power control outputs
	output logic             cpu_clock_gated,
	output logic             oscillator_stop,
	output logic             clock_blocked,
	output var  logic        system_tick,
	// baud timer and serial controls
	output var  logic        baud_overflow,
	output logic             baud_double,
	output logic             frame_error_select
);

	localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYCLES - 1);

	function automatic logic [6:0] div_mask(input logic [2:0] sel);
		div_mask = 7'((8'h01 << sel) - 8'h01);
	endfunction

	function automatic logic hit(input logic [9:0] addr, input logic [7:0] idx);
		hit = (addr == {idx, 2'b00});
	endfunction

	// register state
	wake_clock_out_t wake_and_clock_out_control_q;
	logic [2:0]      divider_field_q;
	logic [7:0]      baud_timer_reload_q;
	logic [1:0]      baud_ctrl_q;
	logic            baud_double_q;
	logic            frame_error_select_q;
	logic            low_voltage_flag_q;
	logic            power_on_flag_q;
	logic            general_flag_one_q;
	logic            general_flag_zero_q;
	logic            idle_select_q;
	power_state_t    state_q;
	logic [15:0]     settle_cnt_q;

	// bus handshake
	logic ack_q;
	logic req;
	logic wr_low;
	logic wr_pc;
	logic wr_wc;
	logic wr_div;
	logic wr_brt;
	logic wr_bctl;
	logic [7:0] wd;

	assign req         = read | write;
	assign waitrequest = req & ~ack_q;
	assign wr_low      = write & ~ack_q & byteenable[0];
	assign wd          = writedata[7:0];

	always_comb begin
		wr_pc   = 1'b0;
		wr_wc   = 1'b0;
		wr_div  = 1'b0;
		wr_brt  = 1'b0;
		wr_bctl = 1'b0;
		if (hit(address, `IDX_POWER_CONTROL)) begin
			wr_pc = wr_low;
		end else if (hit(address, `IDX_WAKE_CLOCK_OUT)) begin
			wr_wc = wr_low;
		end else if (hit(address, `IDX_CLOCK_DIVIDER)) begin
			wr_div = wr_low;
		end else if (hit(address, `IDX_BAUD_RELOAD)) begin
			wr_brt = wr_low;
		end else if (hit(address, `IDX_BAUD_TIMER_CTRL)) begin
			wr_bctl = wr_low;
		end
	end

	// one wait cycle, then the answer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	logic [7:0] pc_view;
	assign pc_view = {baud_double_q, frame_error_select_q, low_voltage_flag_q, power_on_flag_q,
		general_flag_one_q, general_flag_zero_q, (state_q != ST_RUN), idle_select_q};

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			readdata <= 32'h0000_0000;
		end else if (read & ~ack_q) begin
			if (hit(address, `IDX_POWER_CONTROL)) begin
				readdata <= {24'h00_0000, pc_view};
			end else if (hit(address, `IDX_WAKE_CLOCK_OUT)) begin
				readdata <= {24'h00_0000, wake_and_clock_out_control_q};
			end else if (hit(address, `IDX_CLOCK_DIVIDER)) begin
				readdata <= {29'h0000_0000, divider_field_q};
			end else if (hit(address, `IDX_BAUD_RELOAD)) begin
				readdata <= {24'h00_0000, baud_timer_reload_q};
			end else if (hit(address, `IDX_BAUD_TIMER_CTRL)) begin
				readdata <= {30'h0000_0000, baud_ctrl_q};
			end else begin
				readdata <= 32'h0000_0000;
			end
		end
	end

	// control registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wake_and_clock_out_control_q         <= `RST_WAKE_CLOCK_OUT;
			divider_field_q     <= `RST_CLOCK_DIVIDER;
			baud_timer_reload_q <= `RST_BAUD_RELOAD;
			baud_ctrl_q         <= `RST_BAUD_CTRL;
		end else begin
			if (wr_wc) begin
				wake_and_clock_out_control_q <= wake_clock_out_t'(wd);
			end
			if (wr_div) begin
				divider_field_q <= wd[2:0];
			end
			if (wr_brt) begin
				baud_timer_reload_q <= wd;
			end
			if (wr_bctl) begin
				baud_ctrl_q <= wd[1:0];
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			baud_double_q        <= 1'b0;
			frame_error_select_q <= 1'b0;
			general_flag_one_q   <= 1'b0;
			general_flag_zero_q  <= 1'b0;
		end else if (wr_pc) begin
			baud_double_q        <= wd[`PC_BAUD_DOUBLE];
			frame_error_select_q <= wd[`PC_FRAME_ERR_SEL];
			general_flag_one_q   <= wd[`PC_GENERAL_ONE];
			general_flag_zero_q  <= wd[`PC_GENERAL_ZERO];
		end
	end

	assign baud_double        = baud_double_q;
	assign frame_error_select = frame_error_select_q;

	// pin synchronisers
	logic [7:0] pin_s1_q;
	logic [7:0] pin_s2_q;
	logic [7:0] pin_s3_q;
	logic       lvd_s1_q;
	logic       lvd_s2_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_s1_q <= 8'hff;
			pin_s2_q <= 8'hff;
			pin_s3_q <= 8'hff;
			lvd_s1_q <= 1'b0;
			lvd_s2_q <= 1'b0;
		end else begin
			pin_s1_q <= wake_pins;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			lvd_s1_q <= low_voltage_detect;
			lvd_s2_q <= lvd_s1_q;
		end
	end

	// falling edge on each wake pin, qualified by its enables
	wake_pins_t fall;
	wake_pins_t allow;
	logic       pin_wake;

	assign fall = wake_pins_t'(pin_s3_q & ~pin_s2_q);

	always_comb begin
		allow = wake_irq_enable;
		allow.capture_channel_zero_pin &= wake_and_clock_out_control_q.capture_array_wake_enable;
		allow.capture_channel_one_pin  &= wake_and_clock_out_control_q.capture_array_wake_enable;
		allow.rxd_pin                  &= wake_and_clock_out_control_q.receive_pin_wake_enable;
		allow.timer1_pin               &= wake_and_clock_out_control_q.timer1_pin_wake_enable;
		allow.timer0_pin               &= wake_and_clock_out_control_q.timer0_pin_wake_enable;
		allow.comparator_input_pin     &= wake_and_clock_out_control_q.low_voltage_wake_enable;
	end

	assign pin_wake = |(fall & allow);

	// status flags
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			low_voltage_flag_q <= 1'b0;
		end else if (lvd_s2_q) begin
			low_voltage_flag_q <= 1'b1;
		end else if (wr_pc && !wd[`PC_LOW_VOLT_FLAG]) begin
			low_voltage_flag_q <= 1'b0;
		end
	end

	// reset_n stands for the power-on event
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			power_on_flag_q <= 1'b1;
		end else if (wr_pc && !wd[`PC_POWER_ON_FLAG]) begin
			power_on_flag_q <= 1'b0;
		end
	end

	// idle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			idle_select_q <= 1'b0;
		end else if (idle_select_q && irq_request) begin
			idle_select_q <= 1'b0;
		end else if (wr_pc && wd[`PC_IDLE]) begin
			idle_select_q <= 1'b1;
		end
	end

	// power-down sequence
	logic enter_down;
	assign enter_down = (state_q == ST_RUN) && wr_pc && wd[`PC_POWER_DOWN];

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q      <= ST_RUN;
			settle_cnt_q <= 16'h0000;
		end else begin
			case (state_q)
				ST_RUN: begin
					if (enter_down) begin
						state_q <= ST_DOWN;
					end
				end
				ST_DOWN: begin
					if (pin_wake) begin
						state_q      <= ST_SETTLE;
						settle_cnt_q <= 16'h0000;
					end
				end
				ST_SETTLE: begin
					if (settle_cnt_q == SETTLE_LAST) begin
						state_q <= ST_RUN;
					end else begin
						settle_cnt_q <= settle_cnt_q + 16'h0001;
					end
				end
				default: begin
					state_q <= ST_RUN;
				end
			endcase
		end
	end

	logic halted;
	assign halted          = (state_q != ST_RUN);
	assign oscillator_stop = (state_q == ST_DOWN);
	assign clock_blocked   = halted;
	assign cpu_clock_gated = idle_select_q | halted;

	// slow-down divider
	logic [6:0] div_cnt_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt_q   <= 7'h00;
			system_tick <= 1'b0;
		end else if (halted || enter_down) begin
			// no tick may stand in the first halted cycle
			div_cnt_q   <= 7'h00;
			system_tick <= 1'b0;
		end else begin
			// tick once per 2**field cycles
			system_tick <= ((div_cnt_q & div_mask(divider_field_q)) == div_mask(divider_field_q));
			div_cnt_q   <= div_cnt_q + 7'h01;
		end
	end

	// baud-rate timer
	logic [3:0] pre_cnt_q;
	logic [7:0] baud_cnt_q;
	logic       baud_step;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pre_cnt_q <= 4'h0;
		end else if (halted || !baud_ctrl_q[`BT_RUN] || pre_cnt_q == 4'(`PRESCALE_DIV - 1)) begin
			pre_cnt_q <= 4'h0;
		end else begin
			pre_cnt_q <= pre_cnt_q + 4'h1;
		end
	end

	assign baud_step = baud_ctrl_q[`BT_RUN] && !halted &&
		(baud_ctrl_q[`BT_SPEED] || pre_cnt_q == 4'(`PRESCALE_DIV - 1));

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			baud_cnt_q    <= 8'h00;
			baud_overflow <= 1'b0;
		end else begin
			baud_overflow <= 1'b0;
			if (baud_step) begin
				if (baud_cnt_q == 8'hff) begin
					baud_cnt_q    <= baud_timer_reload_q;
					baud_overflow <= 1'b1;
				end else begin
					baud_cnt_q <= baud_cnt_q + 8'h01;
				end
			end
		end
	end

	// clock-out toggles
	logic tog0_q;
	logic tog1_q;
	logic tog2_q;

	// timer pulses already carry the reload, prescale and counter-mode laws
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tog0_q <= 1'b0;
			tog1_q <= 1'b0;
			tog2_q <= 1'b0;
		end else begin
			if (wake_and_clock_out_control_q.timer0_clock_out_enable && timer0_overflow) begin
				tog0_q <= ~tog0_q;
			end
			if (wake_and_clock_out_control_q.timer1_clock_out_enable && timer1_overflow) begin
				tog1_q <= ~tog1_q;
			end
			if (wake_and_clock_out_control_q.baud_timer_clock_out_enable && baud_overflow) begin
				tog2_q <= ~tog2_q;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			clock_out0_pin <= 1'b1;
			clock_out1_pin <= 1'b1;
			clock_out2_pin <= 1'b1;
		end else begin
			clock_out0_pin <= wake_and_clock_out_control_q.timer0_clock_out_enable ? tog0_q : port_latch_timer0_pin;
			clock_out1_pin <= wake_and_clock_out_control_q.timer1_clock_out_enable ? tog1_q : port_latch_timer1_pin;
			clock_out2_pin <= wake_and_clock_out_control_q.baud_timer_clock_out_enable ? tog2_q : port_latch_baud_pin;
		end
	end

endmodule
`default_nettype wire

//--- rtl/pwr_clk_cfg.svh
// register map, field positions, reset values and timing counts of the power and clock-out block
// assumes a 40 MHz system clock and byte addressing on the register bus
`ifndef PWR_CLK_CFG_SVH
`define PWR_CLK_CFG_SVH

// register indexes; byte address is four times the index
`define IDX_POWER_CONTROL     8'h87
`define IDX_WAKE_CLOCK_OUT    8'h8f
`define IDX_CLOCK_DIVIDER     8'h97
`define IDX_BAUD_RELOAD       8'h9c
`define IDX_BAUD_TIMER_CTRL   8'ha0

// power control bits
`define PC_BAUD_DOUBLE        7
`define PC_FRAME_ERR_SEL      6
`define PC_LOW_VOLT_FLAG      5
`define PC_POWER_ON_FLAG      4
`define PC_GENERAL_ONE        3
`define PC_GENERAL_ZERO       2
`define PC_POWER_DOWN         1
`define PC_IDLE               0

// baud timer control bits
`define BT_RUN                0
`define BT_SPEED              1

// reset values
`define RST_WAKE_CLOCK_OUT    8'h00
`define RST_CLOCK_DIVIDER     3'h0
`define RST_BAUD_RELOAD       8'h00
`define RST_BAUD_CTRL         2'h0

// timing
`define CLK_FREQ_HZ           40000000
`define SETTLE_OSC_CYCLES     32768
`define PRESCALE_DIV          12

`endif

//--- rtl/pwr_clk_pkg.sv
// types shared by the power and clock-out block
// no assumptions beyond the matching _cfg header
package pwr_clk_pkg;

	typedef enum logic [2:0] {
		ST_RUN    = 3'b001,
		ST_DOWN   = 3'b010,
		ST_SETTLE = 3'b100
	} power_state_t;

	typedef struct packed {
		logic capture_array_wake_enable;
		logic receive_pin_wake_enable;
		logic timer1_pin_wake_enable;
		logic timer0_pin_wake_enable;
		logic low_voltage_wake_enable;
		logic baud_timer_clock_out_enable;
		logic timer1_clock_out_enable;
		logic timer0_clock_out_enable;
	} wake_clock_out_t;

	// wake pins in order of bit index
	typedef struct packed {
		logic comparator_input_pin;
		logic capture_channel_one_pin;
		logic capture_channel_zero_pin;
		logic rxd_pin;
		logic timer1_pin;
		logic timer0_pin;
		logic external_interrupt_one;
		logic external_interrupt_zero;
	} wake_pins_t;

endpackage

//--- verif/pmcc_sva.sv
// assertions on the ports of the power and clock-out block
// assumes a bind from the bench top file
`timescale 1ns/10ps
`default_nettype none
module pmcc_sva
	import pwr_clk_pkg::*;
#(
	parameter int unsigned SETTLE_CYCLES = 8
) (
	// clock and reset
	input wire logic        clk,
	input wire logic        reset_n,
	// bus
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic        waitrequest,
	// wake and timers
	input wire wake_pins_t  wake_pins,
	input wire wake_pins_t  wake_irq_enable,
	input wire logic        irq_request,
	input wire logic        timer0_overflow,
	input wire logic        timer1_overflow,
	input wire logic        port_latch_timer0_pin,
	input wire logic        port_latch_timer1_pin,
	// outputs
	input wire logic        clock_out0_pin,
	input wire logic        clock_out1_pin,
	input wire logic        clock_out2_pin,
	input wire logic        cpu_clock_gated,
	input wire logic        oscillator_stop,
	input wire logic        clock_blocked,
	input wire logic        system_tick
);
	logic [15:0] cnt_q;

	// length of the current settle run
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			cnt_q <= 16'h0;
		else
			cnt_q <= (clock_blocked && !oscillator_stop) ? cnt_q + 16'h1 : 16'h0;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_wait_once: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
		else $error("bus answer not after one wait cycle");
	a_wait_needs_req: assert property (waitrequest |-> read || write)
		else $error("waitrequest without request");
	a_down_entry: assert property ($rose(oscillator_stop) |-> $past(write) && $past(writedata[1]))
		else $error("power-down entered without write");
	a_down_blocks: assert property (oscillator_stop |-> clock_blocked && cpu_clock_gated)
		else $error("clock not blocked in power-down");
	a_halt_no_tick: assert property (clock_blocked |-> !system_tick)
		else $error("tick while halted");
	a_settle_len: assert property ($fell(clock_blocked) |-> cnt_q == SETTLE_CYCLES)
		else $error("settle length wrong");
	a_wake_external_interrupt_zero: assert property (oscillator_stop && wake_irq_enable.external_interrupt_zero
		&& $fell(wake_pins.external_interrupt_zero) |-> ##[1:4] !oscillator_stop)
		else $error("no wake after pin edge");
	a_idle_irq: assert property (cpu_clock_gated && !clock_blocked && irq_request |=> !cpu_clock_gated)
		else $error("idle not ended by interrupt");
	a_out0_cause: assert property (!$stable(clock_out0_pin) |-> $past(timer0_overflow, 2)
		|| clock_out0_pin == $past(port_latch_timer0_pin) || $past(write, 2))
		else $error("clock out 0 changed without cause");
	a_out1_cause: assert property (!$stable(clock_out1_pin) |-> $past(timer1_overflow, 2)
		|| clock_out1_pin == $past(port_latch_timer1_pin) || $past(write, 2))
		else $error("clock out 1 changed without cause");

	c_settle: cover property ($fell(clock_blocked));
	c_idle_irq: cover property (cpu_clock_gated && irq_request);
	c_out2: cover property (!$stable(clock_out2_pin));
endmodule
`default_nettype wire

//--- verif/power_mode_and_clock_out_ctrl_bench.sv
// bench for the power and clock-out block: bus tasks and directed sequences
// assumes the design, its package, header, timer model and checker compiled first
`timescale 1ns/10ps
`default_nettype none
`include "pwr_clk_cfg.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("wrong value at %0t: %h vs %h", $time, (g), (e)); end end
module power_mode_and_clock_out_ctrl_bench
	import pwr_clk_pkg::*;
;
	localparam logic [9:0] adr_pc = {`IDX_POWER_CONTROL, 2'b00};
	localparam logic [9:0] adr_wk = {`IDX_WAKE_CLOCK_OUT, 2'b00};
	localparam logic [9:0] adr_dv = {`IDX_CLOCK_DIVIDER, 2'b00};
	localparam logic [9:0] adr_br = {`IDX_BAUD_RELOAD, 2'b00};
	localparam logic [9:0] adr_bt = {`IDX_BAUD_TIMER_CTRL, 2'b00};
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [9:0]  address = '0;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = '0;
	logic [3:0]  byteenable = '0;
	logic [31:0] readdata;
	logic        waitrequest;
	wake_pins_t  wake_pins = '1;
	wake_pins_t  wake_irq_enable = '0;
	logic        low_voltage_detect = 1'b0;
	logic        irq_request = 1'b0;
	logic        timer0_overflow, timer1_overflow;
	logic        port_latch_timer0_pin = 1'b1, port_latch_timer1_pin = 1'b1, port_latch_baud_pin = 1'b1;
	logic        clock_out0_pin, clock_out1_pin, clock_out2_pin;
	logic        cpu_clock_gated, oscillator_stop, clock_blocked, system_tick;
	logic        baud_overflow, baud_double, frame_error_select;
	int          mismatches = 0;
	int          n_checks = 0;
	int          cnt [5];
	logic [7:0]  wk_tab [8] = '{8'h00, 8'h00, 8'h10, 8'h20, 8'h40, 8'h80, 8'h80, 8'h08};

	always #12.5 clk = ~clk;

	timer_overflow_model timer_overflow_model_inst0 (.clk(clk), .reset_n(reset_n), .speed_fast(1'b1),
		.reload(8'hf6), .overflow(timer0_overflow));
	timer_overflow_model timer_overflow_model_inst1 (.clk(clk), .reset_n(reset_n), .speed_fast(1'b0),
		.reload(8'hfe), .overflow(timer1_overflow));
	power_mode_and_clock_out_ctrl #(.SETTLE_CYCLES(8)) power_mode_and_clock_out_ctrl_inst (.clk(clk),
		.reset_n(reset_n), .address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .wake_pins(wake_pins),
		.low_voltage_detect(low_voltage_detect), .wake_irq_enable(wake_irq_enable), .irq_request(irq_request),
		.timer0_overflow(timer0_overflow), .timer1_overflow(timer1_overflow),
		.port_latch_timer0_pin(port_latch_timer0_pin), .port_latch_timer1_pin(port_latch_timer1_pin),
		.port_latch_baud_pin(port_latch_baud_pin), .clock_out0_pin(clock_out0_pin),
		.clock_out1_pin(clock_out1_pin), .clock_out2_pin(clock_out2_pin), .cpu_clock_gated(cpu_clock_gated),
		.oscillator_stop(oscillator_stop), .clock_blocked(clock_blocked), .system_tick(system_tick),
		.baud_overflow(baud_overflow), .baud_double(baud_double), .frame_error_select(frame_error_select));

	task automatic end_of_test();
		if (mismatches == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic bus(input logic wr_en, input logic [9:0] a, input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		address <= a;
		writedata <= {24'h0, d};
		byteenable <= 4'h1;
		write <= wr_en;
		read <= !wr_en;
		do begin
			@(posedge clk);
			n++;
			if (n > 20) begin
				mismatches++;
				end_of_test();
			end
		end while (waitrequest !== 1'b0);
		q = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		`CHK(q, e)
	endtask

	// counts pin toggles (0..2) and pulses (3 baud, 4 tick) over n cycles
	task automatic measure(input int n);
		logic [4:0] s, p;
		cnt = '{default: 0};
		@(negedge clk);
		p = {system_tick, baud_overflow, clock_out2_pin, clock_out1_pin, clock_out0_pin};
		repeat (n) begin
			@(negedge clk);
			s = {system_tick, baud_overflow, clock_out2_pin, clock_out1_pin, clock_out0_pin};
			for (int i = 0; i < 5; i++)
				cnt[i] += (i > 2) ? int'(s[i]) : int'(s[i] != p[i]);
			p = s;
		end
		@(posedge clk);
	endtask

	task automatic wait_run();
		int n;
		n = 0;
		while (clock_blocked !== 1'b0) begin
			@(negedge clk);
			n++;
			if (n > 40) begin
				mismatches++;
				end_of_test();
			end
		end
		@(posedge clk);
	endtask

	task automatic pd(input int idx, input logic [7:0] wk, input logic woke);
		wr(adr_wk, wk);
		wake_irq_enable <= 8'h01 | (8'h01 << idx);
		wr(adr_pc, 8'h02);
		`CHK(oscillator_stop, 1'b1)
		wake_pins[idx] <= 1'b0;
		repeat (8) @(negedge clk);
		`CHK(oscillator_stop, !woke)
		@(posedge clk);
		wake_pins[0] <= 1'b0;
		wait_run();
		wake_pins <= '1;
		repeat (4) @(posedge clk);
		rd_chk(adr_pc, 8'h00);
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		mismatches++;
		end_of_test();
	end

	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		rd_chk(adr_pc, 8'h10);
		rd_chk(adr_wk, 8'h00);
		rd_chk(adr_dv, 8'h00);
		rd_chk(adr_br, 8'h00);
		rd_chk(10'h004, 8'h00);
		wr(adr_pc, 8'hcc);
		rd_chk(adr_pc, 8'hcc);
		`CHK({baud_double, frame_error_select}, 2'b11)
		wr(adr_pc, 8'h00);
		`CHK({baud_double, frame_error_select}, 2'b00)
		low_voltage_detect <= 1'b1;
		repeat (4) @(posedge clk);
		low_voltage_detect <= 1'b0;
		repeat (4) @(posedge clk);
		rd_chk(adr_pc, 8'h20);
		wr(adr_pc, 8'h00);
		rd_chk(adr_pc, 8'h00);
		for (int f = 0; f < 8; f++) begin
			wr(adr_dv, f[7:0]);
			rd_chk(adr_dv, f[7:0]);
			measure(256);
			`CHK(cnt[4], 256 >> f)
		end
		wr(adr_dv, 8'h00);
		wr(adr_wk, 8'h07);
		for (int sp = 0; sp < 2; sp++) begin
			wr(adr_br, sp[0] ? 8'hfa : 8'hfe);
			wr(adr_bt, {6'h0, sp[0], 1'b1});
			repeat (3100) @(posedge clk);
			measure(240);
			`CHK(cnt[0], 24)
			`CHK(cnt[1], 10)
			`CHK(cnt[2], sp[0] ? 40 : 10)
			`CHK(cnt[3], sp[0] ? 40 : 10)
		end
		wr(adr_wk, 8'h00);
		port_latch_timer0_pin <= 1'b0;
		port_latch_timer1_pin <= 1'b0;
		port_latch_baud_pin <= 1'b0;
		repeat (3) @(negedge clk);
		`CHK({clock_out2_pin, clock_out1_pin, clock_out0_pin}, 3'b000)
		measure(48);
		`CHK(cnt[0] + cnt[1] + cnt[2], 0)
		port_latch_timer0_pin <= 1'b1;
		port_latch_timer1_pin <= 1'b1;
		port_latch_baud_pin <= 1'b1;
		wr(adr_pc, 8'h01);
		`CHK(cpu_clock_gated, 1'b1)
		measure(16);
		`CHK(cnt[4], 16)
		irq_request <= 1'b1;
		@(posedge clk);
		irq_request <= 1'b0;
		@(negedge clk);
		`CHK(cpu_clock_gated, 1'b0)
		@(posedge clk);
		rd_chk(adr_pc, 8'h00);
		for (int i = 0; i < 8; i++)
			pd(i, wk_tab[i], 1'b1);
		pd(2, 8'h00, 1'b0);
		end_of_test();
	end
endmodule

bind power_mode_and_clock_out_ctrl pmcc_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) pmcc_sva_inst (.clk(clk),
	.reset_n(reset_n), .read(read), .write(write), .writedata(writedata), .waitrequest(waitrequest),
	.wake_pins(wake_pins), .wake_irq_enable(wake_irq_enable), .irq_request(irq_request),
	.timer0_overflow(timer0_overflow), .timer1_overflow(timer1_overflow),
	.port_latch_timer0_pin(port_latch_timer0_pin), .port_latch_timer1_pin(port_latch_timer1_pin),
	.clock_out0_pin(clock_out0_pin), .clock_out1_pin(clock_out1_pin), .clock_out2_pin(clock_out2_pin),
	.cpu_clock_gated(cpu_clock_gated), .oscillator_stop(oscillator_stop), .clock_blocked(clock_blocked),
	.system_tick(system_tick));
`default_nettype wire

//--- verif/timer_overflow_model.sv
// 8-bit auto-reload timer standing in for timer 0 or timer 1: one-cycle overflow pulses
// assumes the same clock and reset as the block under test
`timescale 1ns/10ps
`default_nettype none
module timer_overflow_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// configuration
	input  wire logic       speed_fast,
	input  wire logic [7:0] reload,
	// overflow pulse
	output logic            overflow
);
	logic [3:0] pre_q;
	logic [7:0] cnt_q;
	logic       step;

	// slow mode steps once every 12 clocks
	assign step = speed_fast || (pre_q == 4'hb);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			pre_q <= 4'h0;
		else
			pre_q <= (pre_q == 4'hb) ? 4'h0 : pre_q + 4'h1;
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= 8'h00;
			overflow <= 1'b0;
		end else begin
			overflow <= step && (cnt_q == 8'hff);
			if (step)
				cnt_q <= (cnt_q == 8'hff) ? reload : cnt_q + 8'h1;
		end
	end
endmodule
`default_nettype wire
